// [icf_pkg.sv]
// Package: register map, field positions and reset values of the interrupt flag block
// Behaviour
// RL1 - Flags set on their events regardless of individual or global enables.
// RL2 - Priority off: bit 7 main control enables all unmasked interrupts, 0 blocks all.
// RL3 - Priority on: bit 7 is high-priority global enable; clearing it blocks everything.
// RL4 - Priority off: bit 6 gates all unmasked peripheral interrupts.
// RL5 - Priority on: bit 6 enables low-priority interrupts.
// RL6 - Main control holds timer0, ext0 and port change enables at bits 5,4,3.
// RL7 - Timer0 flag bit 2 and ext0 flag bit 1 set on events, sticky.
// RL8 - Port change flag bit 0 sets when upper four port pins change, sticky.
// RL9 - Persisting mismatch keeps setting port change flag; port read ends mismatch.
// RL10 - Second control bit 7 disables all pull-ups; else latch values decide.
// RL11 - Second control bits 6,5,4 pick ext0/1/2 edge: 1 rising, 0 falling.
// RL12 - Priority bits: 1 high, 0 low, at documented positions.
// RL13 - Third control holds ext2 enable bit 4, ext1 enable bit 3.
// RL14 - Third control ext2 flag bit 1, ext1 flag bit 0, sticky.
// RL15 - Unimplemented bits of second and third control read zero.
// RL16 - First peripheral flags set on events and stay until software clears.
// RL17 - Receive flag bit 5 read-only, follows receive buffer holding data.
// RL18 - Transmit flag bit 4 read-only, follows transmit buffer empty.
// RL19 - Capture/compare flag sets on capture or compare, unused in PWM.
// RL20 - Parallel port flag absent and zero on smallest package.
// RL21 - Software clears flags before enabling and after servicing.
// RL22 - Priority feature enable bit 7 of reset control selects enable meanings.
// RL23 - Flag, enable and global enable set: vector 0008h high, 0018h low.
// RL24 - Separate high and low request level outputs.
package icf_pkg;
   localparam logic [3:0] ADDR_MAIN = 4'h0;
   localparam logic [3:0] ADDR_EDGE = 4'h4;
   localparam logic [3:0] ADDR_EXT = 4'h8;
   localparam logic [3:0] ADDR_PFLAG = 4'hC;
   localparam logic [7:0] RESET_MAIN = 8'h00;
   localparam logic [7:0] RESET_EDGE = 8'hF5;
   localparam logic [7:0] RESET_EXT = 8'hC0;
   localparam logic [7:0] RESET_PFLAG = 8'h00;
   localparam logic [7:0] MASK_EDGE = 8'hF5;
   localparam logic [7:0] MASK_EXT = 8'hDB;
   localparam int BIT_GHE = 7;
   localparam int BIT_PLE = 6;
   localparam int BIT_T0E = 5;
   localparam int BIT_E0E = 4;
   localparam int BIT_PCE = 3;
   localparam int BIT_T0F = 2;
   localparam int BIT_E0F = 1;
   localparam int BIT_PCF = 0;
   localparam int BIT_PUD = 7;
   localparam int BIT_E0S = 6;
   localparam int BIT_E1S = 5;
   localparam int BIT_E2S = 4;
   localparam int BIT_T0P = 2;
   localparam int BIT_PCP = 0;
   localparam int BIT_E2P = 7;
   localparam int BIT_E1P = 6;
   localparam int BIT_E2E = 4;
   localparam int BIT_E1E = 3;
   localparam int BIT_E2F = 1;
   localparam int BIT_E1F = 0;
   localparam int BIT_PPF = 7;
   localparam int BIT_ADF = 6;
   localparam int BIT_SSF = 3;
   localparam int BIT_T2F = 1;
   localparam int BIT_T1F = 0;
   localparam int BIT_RXF = 5;
   localparam int BIT_TXF = 4;
   localparam int BIT_CCF = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] CCP_CAPTURE = 2'h0;
   localparam logic [1:0] CCP_COMPARE = 2'h1;
   localparam logic [1:0] CCP_PWM = 2'h2;
   localparam logic [15:0] VEC_HIGH = 16'h0008;
   localparam logic [15:0] VEC_LOW = 16'h0018;
endpackage

// [icf_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module icf_pin_sync #(
   parameter int WIDTH = 7
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   // First stage feeds only the second one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // Level moves only once stages two and three agree, per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               level[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
               level[i] <= s3[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [icf_top.sv]
// Interrupt control and flag block with AXI4-Lite register access
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module icf_top #(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic priority_feature_enable,
   input wire logic timer0_overflow,
   input wire logic [2:0] ext_pin,
   input wire logic [3:0] change_port,
   input wire logic change_port_read,
   input wire logic [7:0] port_latch,
   input wire logic parallel_port_event,
   input wire logic converter_done_event,
   input wire logic receive_buffer_full,
   input wire logic transmit_buffer_empty,
   input wire logic sync_serial_event,
   input wire logic [1:0] ccp_mode,
   input wire logic ccp_capture_event,
   input wire logic ccp_compare_event,
   input wire logic timer2_match_event,
   input wire logic timer1_overflow_event,
   input wire logic [7:0] peripheral_enable_first,
   input wire logic [7:0] peripheral_priority_first,
   output logic [7:0] pullup_enable,
   output logic irq_high,
   output logic irq_low,
   output logic [15:0] irq_vector
);
   logic [7:0] main_ctl;
   logic [7:0] edge_ctl;
   logic [7:0] ext_ctl;
   logic [7:0] pflag;
   logic [6:0] pin_level;
   logic [2:0] ext_prev;
   logic [3:0] port_snap;
   logic aw_held;
   logic w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic wr_lane0;
   logic [2:0] ext_edge;
   logic port_mismatch;
   logic [7:0] pflag_event;
   logic [7:0] pflag_rw_mask;
   logic [7:0] rd_byte;
   logic want_high;
   logic want_low;

   // External pins and the change port come from outside the clock domain
   icf_pin_sync #(.WIDTH(7)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin({change_port, ext_pin}),
      .level(pin_level)
   );

   // Previous synchronised ext levels for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_prev <= 3'h0;
      end else begin
         ext_prev <= pin_level[2:0];
      end
   end

   // Edge select: 1 catches rising, 0 catches falling
   always_comb begin
      ext_edge[0] = edge_ctl[icf_pkg::BIT_E0S] ? (pin_level[0] & ~ext_prev[0])
                                                : (~pin_level[0] & ext_prev[0]); // RL11
      ext_edge[1] = edge_ctl[icf_pkg::BIT_E1S] ? (pin_level[1] & ~ext_prev[1])
                                                : (~pin_level[1] & ext_prev[1]); // RL11
      ext_edge[2] = edge_ctl[icf_pkg::BIT_E2S] ? (pin_level[2] & ~ext_prev[2])
                                                : (~pin_level[2] & ext_prev[2]); // RL11
   end

   // Port snapshot is refreshed by a port read; mismatch lasts until then
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_snap <= 4'h0;
      end else if (change_port_read) begin
         port_snap <= pin_level[6:3]; // RL9
      end
   end
   assign port_mismatch = (pin_level[6:3] != port_snap); // RL8

   // Write channel capture: address and data accepted in either order
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_lane0 = wr_fire && w_strb[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= icf_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr <= icf_pkg::ADDR_PFLAG)
                           ? icf_pkg::RESP_OKAY : icf_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Main control: enables by write, flags set by events; set beats clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_ctl <= icf_pkg::RESET_MAIN;
      end else begin
         if (wr_lane0 && aw_addr == icf_pkg::ADDR_MAIN) begin
            main_ctl <= w_data[7:0]; // RL6
         end
         if (timer0_overflow) begin
            main_ctl[icf_pkg::BIT_T0F] <= 1'b1; // RL1 RL7
         end
         if (ext_edge[0]) begin
            main_ctl[icf_pkg::BIT_E0F] <= 1'b1; // RL7
         end
         if (port_mismatch) begin
            main_ctl[icf_pkg::BIT_PCF] <= 1'b1; // RL8 RL9
         end
      end
   end

   // Edge and priority control; unimplemented bits held at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_ctl <= icf_pkg::RESET_EDGE;
      end else if (wr_lane0 && aw_addr == icf_pkg::ADDR_EDGE) begin
         edge_ctl <= w_data[7:0] & icf_pkg::MASK_EDGE; // RL15 RL12
      end
   end

   // External control: ext1/ext2 enables, priorities and flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_ctl <= icf_pkg::RESET_EXT;
      end else begin
         if (wr_lane0 && aw_addr == icf_pkg::ADDR_EXT) begin
            ext_ctl <= w_data[7:0] & icf_pkg::MASK_EXT; // RL13 RL15
         end
         if (ext_edge[1]) begin
            ext_ctl[icf_pkg::BIT_E1F] <= 1'b1; // RL14
         end
         if (ext_edge[2]) begin
            ext_ctl[icf_pkg::BIT_E2F] <= 1'b1; // RL14
         end
      end
   end

   // Peripheral flag events; capture/compare depends on mode, none in PWM
   always_comb begin
      pflag_event = 8'h00;
      pflag_event[icf_pkg::BIT_PPF] = parallel_port_event && !SMALL_PACKAGE; // RL20
      pflag_event[icf_pkg::BIT_ADF] = converter_done_event; // RL16
      pflag_event[icf_pkg::BIT_SSF] = sync_serial_event; // RL16
      pflag_event[icf_pkg::BIT_CCF] =
         (ccp_mode == icf_pkg::CCP_CAPTURE && ccp_capture_event) ||
         (ccp_mode == icf_pkg::CCP_COMPARE && ccp_compare_event); // RL19
      pflag_event[icf_pkg::BIT_T2F] = timer2_match_event; // RL16
      pflag_event[icf_pkg::BIT_T1F] = timer1_overflow_event; // RL16
      pflag_rw_mask = SMALL_PACKAGE ? 8'h4F : 8'hCF;
   end

   // Sticky software-cleared bits plus two status-following serial bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pflag <= icf_pkg::RESET_PFLAG;
      end else begin
         if (wr_lane0 && aw_addr == icf_pkg::ADDR_PFLAG) begin
            pflag <= ((w_data[7:0] & pflag_rw_mask) | pflag_event) & pflag_rw_mask; // RL16
         end else begin
            pflag <= (pflag | pflag_event) & pflag_rw_mask; // RL1 RL16
         end
         pflag[icf_pkg::BIT_RXF] <= receive_buffer_full; // RL17
         pflag[icf_pkg::BIT_TXF] <= transmit_buffer_empty; // RL18
      end
   end

   // Read channel: one read at a time, unmapped answers SLVERR
   always_comb begin
      case (s_axi_araddr)
         icf_pkg::ADDR_MAIN: rd_byte = main_ctl;
         icf_pkg::ADDR_EDGE: rd_byte = edge_ctl;
         icf_pkg::ADDR_EXT: rd_byte = ext_ctl;
         icf_pkg::ADDR_PFLAG: rd_byte = pflag;
         default: rd_byte = 8'h00;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= icf_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rd_byte}; // RL15
            s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= icf_pkg::ADDR_PFLAG)
                           ? icf_pkg::RESP_OKAY : icf_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Request qualification; priority bits ignored with the feature off
   always_comb begin
      logic hi_src;
      logic lo_src;
      logic [7:0] pf_pend;
      hi_src = 1'b0;
      lo_src = 1'b0;
      pf_pend = pflag & peripheral_enable_first;
      if (!priority_feature_enable) begin
         // Core sources gated by bit 7 only, peripherals also by bit 6
         want_high = main_ctl[icf_pkg::BIT_GHE] && (
            (main_ctl[icf_pkg::BIT_T0F] && main_ctl[icf_pkg::BIT_T0E]) ||
            (main_ctl[icf_pkg::BIT_E0F] && main_ctl[icf_pkg::BIT_E0E]) ||
            (main_ctl[icf_pkg::BIT_PCF] && main_ctl[icf_pkg::BIT_PCE]) ||
            (ext_ctl[icf_pkg::BIT_E1F] && ext_ctl[icf_pkg::BIT_E1E]) ||
            (ext_ctl[icf_pkg::BIT_E2F] && ext_ctl[icf_pkg::BIT_E2E]) ||
            (main_ctl[icf_pkg::BIT_PLE] && (pf_pend != 8'h00))); // RL2 RL4
         want_low = 1'b0;
      end else begin
         // Ext0 is always high priority
         hi_src = (main_ctl[icf_pkg::BIT_E0F] && main_ctl[icf_pkg::BIT_E0E]) ||
            (main_ctl[icf_pkg::BIT_T0F] && main_ctl[icf_pkg::BIT_T0E]
             && edge_ctl[icf_pkg::BIT_T0P]) ||
            (main_ctl[icf_pkg::BIT_PCF] && main_ctl[icf_pkg::BIT_PCE]
             && edge_ctl[icf_pkg::BIT_PCP]) ||
            (ext_ctl[icf_pkg::BIT_E1F] && ext_ctl[icf_pkg::BIT_E1E]
             && ext_ctl[icf_pkg::BIT_E1P]) ||
            (ext_ctl[icf_pkg::BIT_E2F] && ext_ctl[icf_pkg::BIT_E2E]
             && ext_ctl[icf_pkg::BIT_E2P]) ||
            ((pf_pend & peripheral_priority_first) != 8'h00); // RL12
         lo_src = (main_ctl[icf_pkg::BIT_T0F] && main_ctl[icf_pkg::BIT_T0E]
             && !edge_ctl[icf_pkg::BIT_T0P]) ||
            (main_ctl[icf_pkg::BIT_PCF] && main_ctl[icf_pkg::BIT_PCE]
             && !edge_ctl[icf_pkg::BIT_PCP]) ||
            (ext_ctl[icf_pkg::BIT_E1F] && ext_ctl[icf_pkg::BIT_E1E]
             && !ext_ctl[icf_pkg::BIT_E1P]) ||
            (ext_ctl[icf_pkg::BIT_E2F] && ext_ctl[icf_pkg::BIT_E2E]
             && !ext_ctl[icf_pkg::BIT_E2P]) ||
            ((pf_pend & ~peripheral_priority_first) != 8'h00);
         want_high = main_ctl[icf_pkg::BIT_GHE] && hi_src; // RL3 RL22
         want_low = main_ctl[icf_pkg::BIT_GHE] && main_ctl[icf_pkg::BIT_PLE]
                    && lo_src; // RL3 RL5
      end
   end

   // Registered request levels, vector and pull-ups
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_high <= 1'b0;
         irq_low <= 1'b0;
         irq_vector <= icf_pkg::VEC_HIGH;
         pullup_enable <= 8'h00;
      end else begin
         irq_high <= want_high; // RL24
         irq_low <= want_low; // RL24
         irq_vector <= (!want_high && want_low) ? icf_pkg::VEC_LOW : icf_pkg::VEC_HIGH; // RL23
         pullup_enable <= edge_ctl[icf_pkg::BIT_PUD] ? 8'h00 : port_latch; // RL10
      end
   end

   // Flag stays set while its event repeats
   // Checks look at registered state, raw inputs and the combinational edge and mismatch terms; all are off while reset is low
   t0_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
      timer0_overflow |=> main_ctl[icf_pkg::BIT_T0F])
      else $error("timer0 flag not set");
   ext1_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
      ext_edge[1] |=> ext_ctl[icf_pkg::BIT_E1F])
      else $error("ext1 flag not set");
   port_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
      port_mismatch |=> main_ctl[icf_pkg::BIT_PCF])
      else $error("port change flag lost during mismatch");
   gie_block_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      !main_ctl[icf_pkg::BIT_GHE] |=> !irq_high && !irq_low)
      else $error("request with global enable off");
   low_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
      !main_ctl[icf_pkg::BIT_PLE] |=> !irq_low)
      else $error("low request with low enable off");
   rx_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
      ##1 pflag[icf_pkg::BIT_RXF] == $past(receive_buffer_full))
      else $error("receive flag not following buffer");
   unimpl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
      (edge_ctl & ~icf_pkg::MASK_EDGE) == 8'h00 && (ext_ctl & ~icf_pkg::MASK_EXT) == 8'h00)
      else $error("unimplemented bit set");
   pullup_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
      edge_ctl[icf_pkg::BIT_PUD] |=> pullup_enable == 8'h00)
      else $error("pull-ups enabled while disabled");
   small_pkg_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
      parallel_port_event |=> pflag[icf_pkg::BIT_PPF] == !SMALL_PACKAGE)
      else $error("parallel flag wrong for package");
endmodule
`default_nettype wire

// [icf_evt_src.sv]
// Peripheral event source model: event pulses that copy each request one cycle later
`timescale 1ns/1ns
`default_nettype none
module icf_evt_src (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] fire,
   output logic [7:0] pulse
);
   // Registered so every request reaches the block one cycle later, for as many cycles as it is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse <= 8'h00;
      end else begin
         pulse <= fire;
      end
   end
endmodule
`default_nettype wire

// [tb_interrupt_control_flags.sv]
// Self-checking bench for the interrupt control and flag block
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_control_flags;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, change_port = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, priority_feature_enable = 1'b0, change_port_read = 1'b0;
   logic receive_buffer_full = 1'b0, transmit_buffer_empty = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [2:0] ext_pin = 3'h0;
   logic [7:0] port_latch = 8'h00, peripheral_enable_first = 8'h00, fire = 8'h00;
   logic [7:0] peripheral_priority_first = 8'h00;
   logic [1:0] ccp_mode = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_high, irq_low;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] pullup_enable, pulse;
   logic [15:0] irq_vector;
   int error_cnt = 0;
   int n_compared = 0;

   // Free-running system clock, 40 ns period
   initial begin
      forever #20 aclk = ~aclk;
   end

   icf_evt_src evt_u (.aclk, .aresetn, .fire, .pulse);
   icf_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .priority_feature_enable, .timer0_overflow(pulse[5]), .ext_pin, .change_port,
      .change_port_read, .port_latch, .parallel_port_event(pulse[7]),
      .converter_done_event(pulse[6]), .receive_buffer_full, .transmit_buffer_empty,
      .sync_serial_event(pulse[3]), .ccp_mode, .ccp_capture_event(pulse[2]),
      .ccp_compare_event(pulse[4]), .timer2_match_event(pulse[1]),
      .timer1_overflow_event(pulse[0]), .peripheral_enable_first, .peripheral_priority_first,
      .pullup_enable, .irq_high, .irq_low, .irq_vector);

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // A bus answer that never comes ends the run at once
   task automatic hang();
      error_cnt++;
      $display("BAD %0t bus gave no answer", $time);
      end_sim();
   endtask

   // Address and data offered together, each released once taken
   task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (i == 50) hang();
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (i == 50) hang();
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic w(input logic [3:0] a, input logic [7:0] d);
      logic [1:0] r;
      wr(a, d, r);
   endtask

   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk({8'h0, d}, {8'h0, e});
      chk({14'h0, r}, {14'h0, icf_pkg::RESP_OKAY});
   endtask

   // One-cycle event request through the source model
   task automatic ev(input logic [7:0] m);
      fire <= m;
      cyc(1);
      fire <= 8'h00;
      cyc(4);
   endtask

   // Expected {high, low} request for one active source
   function automatic logic [1:0] irq_exp(input logic pe, input logic [1:0] g, input logic hi,
      input logic per);
      if (!pe) return {g[1] & (g[0] | ~per), 1'b0};
      return hi ? {g[1], 1'b0} : {1'b0, g[1] & g[0]};
   endfunction

   initial begin
      logic [7:0] d;
      logic [1:0] r;
      logic [1:0] q;
      int k;
      void'($urandom(32'h4615));
      cyc(6);
      aresetn <= 1'b1;
      cyc(1);
      rc(icf_pkg::ADDR_MAIN, icf_pkg::RESET_MAIN);
      rc(icf_pkg::ADDR_EDGE, icf_pkg::RESET_EDGE);
      rc(icf_pkg::ADDR_EXT, icf_pkg::RESET_EXT);
      rc(icf_pkg::ADDR_PFLAG, icf_pkg::RESET_PFLAG);
      rd(4'h2, d, r);
      chk({14'h0, r}, {14'h0, icf_pkg::RESP_SLVERR});
      chk({8'h0, d}, 16'h0000);
      wr(4'h2, 8'hFF, r);
      chk({14'h0, r}, {14'h0, icf_pkg::RESP_SLVERR});
      // Lane 0 strobe low: the write must leave the register alone
      s_axi_wstrb <= 4'hE;
      w(icf_pkg::ADDR_MAIN, 8'hFF);
      s_axi_wstrb <= 4'hF;
      rc(icf_pkg::ADDR_MAIN, icf_pkg::RESET_MAIN);
      $display("test reset done");
      // Edge selects kept at rising so no pin edge appears mid-test
      repeat (8) begin
         d = 8'($urandom);
         w(icf_pkg::ADDR_EDGE, d | 8'h70);
         rc(icf_pkg::ADDR_EDGE, (d | 8'h70) & icf_pkg::MASK_EDGE);
         w(icf_pkg::ADDR_EXT, d);
         rc(icf_pkg::ADDR_EXT, d & icf_pkg::MASK_EXT);
         w(icf_pkg::ADDR_MAIN, d & 8'hFE);
         rc(icf_pkg::ADDR_MAIN, d & 8'hFE);
      end
      $display("test registers done");
      w(icf_pkg::ADDR_MAIN, 8'h00);
      w(icf_pkg::ADDR_EXT, 8'h00);
      repeat (6) begin
         d = 8'($urandom) & 8'hEF;
         ev(d);
         rc(icf_pkg::ADDR_MAIN, {5'h0, d[5], 2'h0});
         rc(icf_pkg::ADDR_PFLAG, d & 8'hCF);
         w(icf_pkg::ADDR_MAIN, 8'h00);
         w(icf_pkg::ADDR_PFLAG, 8'h00);
         rc(icf_pkg::ADDR_PFLAG, 8'h00);
      end
      for (k = 0; k < 3; k++) begin
         ccp_mode <= 2'(k);
         ev((k == 0) ? 8'h04 : ((k == 1) ? 8'h10 : 8'h14));
         rc(icf_pkg::ADDR_PFLAG, (k == 2) ? 8'h00 : 8'h04);
         w(icf_pkg::ADDR_PFLAG, 8'h00);
      end
      receive_buffer_full <= 1'b1;
      transmit_buffer_empty <= 1'b1;
      cyc(3);
      w(icf_pkg::ADDR_PFLAG, 8'h00);
      rc(icf_pkg::ADDR_PFLAG, 8'h30);
      receive_buffer_full <= 1'b0;
      transmit_buffer_empty <= 1'b0;
      cyc(3);
      w(icf_pkg::ADDR_PFLAG, 8'h30);
      rc(icf_pkg::ADDR_PFLAG, 8'h00);
      $display("test events done");
      port_latch <= 8'($urandom);
      w(icf_pkg::ADDR_EDGE, 8'h75);
      cyc(2);
      chk({8'h0, pullup_enable}, {8'h0, port_latch});
      w(icf_pkg::ADDR_EDGE, 8'hF5);
      cyc(2);
      chk({8'h0, pullup_enable}, 16'h0000);
      // Pin first parked on the idle side; flags from that move are cleared
      for (k = 0; k < 6; k++) begin
         ext_pin <= {3{~k[0]}};
         w(icf_pkg::ADDR_EDGE, {1'b1, {3{k[0]}}, 4'h5});
         cyc(8);
         w(icf_pkg::ADDR_MAIN, 8'h00);
         w(icf_pkg::ADDR_EXT, 8'h00);
         ext_pin[k/2] <= k[0];
         cyc(8);
         rc(icf_pkg::ADDR_MAIN, {6'h0, k / 2 == 0, 1'b0});
         rc(icf_pkg::ADDR_EXT, {6'h0, k / 2 == 2, k / 2 == 1});
         w(icf_pkg::ADDR_MAIN, 8'h00);
         w(icf_pkg::ADDR_EXT, 8'h00);
         ext_pin[k/2] <= ~k[0];
         cyc(8);
         rc(icf_pkg::ADDR_MAIN, 8'h00);
         rc(icf_pkg::ADDR_EXT, 8'h00);
      end
      $display("test pins done");
      change_port <= 4'($urandom) | 4'h1;
      cyc(8);
      rc(icf_pkg::ADDR_MAIN, 8'h01);
      w(icf_pkg::ADDR_MAIN, 8'h00);
      rc(icf_pkg::ADDR_MAIN, 8'h01);
      change_port_read <= 1'b1;
      cyc(1);
      change_port_read <= 1'b0;
      cyc(2);
      w(icf_pkg::ADDR_MAIN, 8'h00);
      rc(icf_pkg::ADDR_MAIN, 8'h00);
      $display("test port change done");
      ev(8'h40);
      for (k = 0; k < 32; k++) begin
         priority_feature_enable <= k[3];
         peripheral_enable_first <= {1'b0, k[4], 6'h0};
         peripheral_priority_first <= {1'b0, k[0], 6'h0};
         w(icf_pkg::ADDR_EDGE, {5'h1E, k[0], 2'h1});
         w(icf_pkg::ADDR_MAIN, {k[2:1], ~k[4], 2'b00, ~k[4], 2'b00});
         cyc(3);
         q = irq_exp(k[3], k[2:1], k[0], k[4]);
         chk({14'h0, irq_high, irq_low}, {14'h0, q});
         chk(irq_vector, (q == 2'b01) ? icf_pkg::VEC_LOW : icf_pkg::VEC_HIGH);
      end
      $display("test requests done");
      end_sim();
   end
endmodule
`default_nettype wire
